// [src/fsr_pkg.sv]
// Purpose: Constants and carrier types for the frequency setpoint and ramp block.
// Assumes: Frequencies in 0.01 Hz, times in 0.1 s, carrier in 0.1 kHz, analog in 0.1 %.
// Notes: Register byte addresses are word aligned on the Avalon-MM slave.
//
// Notes on behaviour
// - Maximum frequency 10-600 Hz, default 50 Hz.
// - Upper limit between lower and maximum.
// - Lower limit from zero to upper limit.
// - Start refused while setpoint below lower limit.
// - Keypad source uses keypad setpoint register.
// - Ramp-up time spans zero to maximum.
// - Ramp-down time spans maximum to zero.
// - Slope fixed by maximum, shorter for lower targets.
// - Terminal input selects one of two time pairs.
// - Direction codes: normal, reversed, reverse forbidden.
// - Reversed setting inverts every run command.
// - Reverse forbidden never starts motor backwards; a run already reversed ramps to zero.
// - Parameter restore returns direction to default.
// - Carrier bounded per model class, class defaults.
// - Restore code: none, defaults, erase fault history.
// - Restore field self-clears after its action.
// - Voltage regulation: off, on, off while decelerating.
// - Regulation flag tells stage to hold voltage.
// - Source four takes the multi-step frequency.
// - Source five takes the loop regulator output.
// - Source selector decodes seven channels.
// - Full-scale analog percent maps to maximum frequency.
package fsr_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_MAX_F = 8'h00;
  localparam logic [7:0] ADDR_UPPER_F = 8'h04;
  localparam logic [7:0] ADDR_LOWER_F = 8'h08;
  localparam logic [7:0] ADDR_KEYPAD_F = 8'h0C;
  localparam logic [7:0] ADDR_UP_A = 8'h10;
  localparam logic [7:0] ADDR_DN_A = 8'h14;
  localparam logic [7:0] ADDR_DIR = 8'h18;
  localparam logic [7:0] ADDR_CARRIER = 8'h1C;
  localparam logic [7:0] ADDR_RESTORE = 8'h20;
  localparam logic [7:0] ADDR_AVR = 8'h24;
  localparam logic [7:0] ADDR_UP_B = 8'h28;
  localparam logic [7:0] ADDR_DN_B = 8'h2C;
  localparam logic [7:0] ADDR_SRC = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  localparam logic [7:0] ADDR_OUT_F = 8'h38;
  // Limits and defaults.
  localparam logic [15:0] MAX_F_MIN = 16'h03E8;
  localparam logic [15:0] MAX_F_MAX = 16'hEA60;
  localparam logic [15:0] FREQ_DEF = 16'h1388;
  localparam logic [15:0] TIME_MIN = 16'h0001;
  localparam logic [15:0] TIME_MAX = 16'h8CA0;
  localparam logic [15:0] TIME_DEF = 16'h0064;
  localparam logic [1:0] DIR_NORMAL = 2'h0;
  localparam logic [1:0] DIR_REVERSED = 2'h1;
  localparam logic [1:0] DIR_NO_REV = 2'h2;
  localparam logic [1:0] RST_NONE = 2'h0;
  localparam logic [1:0] RST_DEFAULTS = 2'h1;
  localparam logic [1:0] RST_FAULTS = 2'h2;
  localparam logic [1:0] AVR_OFF = 2'h0;
  localparam logic [1:0] AVR_ON = 2'h1;
  localparam logic [1:0] AVR_NO_DECEL = 2'h2;
  localparam logic [2:0] SRC_KEYPAD = 3'h0;
  localparam logic [2:0] SRC_VOLT = 3'h1;
  localparam logic [2:0] SRC_CURR = 3'h2;
  localparam logic [2:0] SRC_SUM = 3'h3;
  localparam logic [2:0] SRC_STEP = 3'h4;
  localparam logic [2:0] SRC_LOOP = 3'h5;
  localparam logic [2:0] SRC_COMM = 3'h6;
  localparam logic [15:0] CARR_MIN = 16'h000A;
  localparam logic [15:0] CARR_MAX_S = 16'h0096;
  localparam logic [15:0] CARR_MAX_M = 16'h0050;
  localparam logic [15:0] CARR_MAX_L = 16'h003C;
  localparam logic [15:0] CARR_DEF_S = 16'h0050;
  localparam logic [15:0] CARR_DEF_M = 16'h0028;
  localparam logic [15:0] CARR_DEF_L = 16'h0014;
  localparam logic [10:0] PCT_FULL = 11'h3E8;
  // Ramp update tick derived from the clock rate.
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TENTH_S_NS = 100000000;
  localparam logic [7:0] TICKS_PER_TENTH = 8'(TENTH_S_NS / TICK_NS);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} fsr_mode_e;
  // Avalon-MM request from the master.
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } fsr_avs_req_s;
  // Commands to the power stage.
  typedef struct packed {
    logic run;
    logic reverse;
    logic [15:0] freq;
    logic [15:0] carrier;
    logic avr_on;
    logic decel;
  } fsr_drive_s;
endpackage

// [src/fsr_ramp_ctrl.sv]
// Purpose: Frequency source select, limits, two-pair ramp and drive policy.
// Assumes: Inputs synchronous to i_ref_clk; parameters written over Avalon-MM.
// Notes: Every access takes exactly one wait cycle.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module fsr_ramp_ctrl
#(
  parameter int TICK_LEN = fsr_pkg::TICK_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire fsr_pkg::fsr_avs_req_s i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_run_req,
  input wire logic i_run_rev,
  input wire logic i_time_pair_b,
  input wire logic [1:0] i_model_class,
  input wire logic signed [15:0] i_voltage_analog_input,
  input wire logic signed [15:0] i_current_analog_input,
  input wire logic [15:0] i_step_freq,
  input wire logic [15:0] i_loop_freq,
  input wire logic [15:0] i_comm_freq,
  output fsr_pkg::fsr_drive_s o_drive,
  output logic o_fault_clear
);
  import fsr_pkg::*;

  // Whole state of the block.
  typedef struct packed {
    logic [15:0] max_output_freq;
    logic [15:0] upper_freq_limit;
    logic [15:0] lower_freq_limit;
    logic [15:0] keypad_freq_setpoint;
    logic [15:0] ramp_up_time_a;
    logic [15:0] ramp_down_time_a;
    logic [15:0] ramp_up_time_b;
    logic [15:0] ramp_down_time_b;
    logic [1:0] direction_policy;
    logic [15:0] carrier_freq;
    logic [1:0] param_restore_cmd;
    logic [1:0] voltage_regulation_mode;
    logic [2:0] freq_source_select;
    logic init_done;
    fsr_mode_e mode;
    logic rev;
    logic [15:0] freq;
    logic [23:0] acc;
    logic [15:0] tick_cnt;
    logic ack;
    logic [31:0] rdata;
    logic fault_clr;
    logic avr_on;
    logic decel;
  } fsr_state_s;

  fsr_state_s s_reg; // Registered state.
  fsr_state_s s_next; // Next state.
  logic [16:0] sp; // Setpoint: sign bit and magnitude.
  logic want_rev; // Direction that the command asks for.
  logic forbid; // Reverse asked while forbidden.
  logic [15:0] target; // Setpoint clamped to the upper limit.
  logic [15:0] goal; // Frequency the ramp heads to now.
  logic [23:0] den; // Slope denominator in ticks.
  logic [15:0] ramp_t; // Active ramp time.
  logic [15:0] carr_hi; // Carrier ceiling for the class.
  logic [15:0] carr_def; // Carrier default for the class.
  logic tick; // Ramp update tick.
  logic rd_take; // Read accepted, data latched.
  logic wr_fire; // Write takes effect this edge.
  logic signed [16:0] sum_pct; // Sum of both analog inputs.

  // Limits a value into a closed range.
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo)
    begin
      clamp16 = lo;
    end
    else if (v > hi)
    begin
      clamp16 = hi;
    end
    else
    begin
      clamp16 = v;
    end
  endfunction

  // Merges the two low byte lanes of a write into a 16-bit field.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Maps a signed percent in 0.1 % to sign and frequency magnitude.
  function automatic logic [16:0] pct_to_f(input logic signed [16:0] p,
                                           input logic [15:0] mx);
    logic [16:0] a;
    logic [26:0] pr;
    a = p[16] ? 17'(-p) : 17'(p);
    if (a > 17'(PCT_FULL))
    begin
      a = 17'(PCT_FULL);
    end
    pr = 27'(a) * 27'(mx);
    pct_to_f = {p[16], 16'(pr / 27'(PCT_FULL))};
  endfunction

  // Carrier bounds and defaults per model class; code 3 counts as large.
  always_comb
  begin
    unique case (i_model_class)
      2'h0:
      begin
        carr_hi = CARR_MAX_S;
        carr_def = CARR_DEF_S;
      end
      2'h1:
      begin
        carr_hi = CARR_MAX_M;
        carr_def = CARR_DEF_M;
      end
      default:
      begin
        carr_hi = CARR_MAX_L;
        carr_def = CARR_DEF_L;
      end
    endcase
  end

  // Picks the frequency source and derives the ramp goal.
  always_comb
  begin
    sum_pct = 17'(i_voltage_analog_input) + 17'(i_current_analog_input);
    unique case (s_reg.freq_source_select)
      SRC_KEYPAD: sp = {1'b0, s_reg.keypad_freq_setpoint};
      SRC_VOLT: sp = pct_to_f(17'(i_voltage_analog_input), s_reg.max_output_freq);
      SRC_CURR: sp = pct_to_f(17'(i_current_analog_input), s_reg.max_output_freq);
      SRC_SUM: sp = pct_to_f(sum_pct, s_reg.max_output_freq);
      SRC_STEP: sp = {1'b0, i_step_freq};
      SRC_LOOP: sp = {1'b0, i_loop_freq};
      SRC_COMM: sp = {1'b0, i_comm_freq};
      default: sp = 17'h00000;
    endcase
    // Reversed setting flips every command.
    want_rev = i_run_rev ^ sp[16] ^ (s_reg.direction_policy == DIR_REVERSED);
    forbid = want_rev && (s_reg.direction_policy == DIR_NO_REV);
    target = (sp[15:0] > s_reg.upper_freq_limit) ? s_reg.upper_freq_limit : sp[15:0];
    // Ramp to zero on stop, on a pending direction change or when reverse is barred.
    if (s_reg.mode == ST_RUN && !forbid && want_rev == s_reg.rev)
    begin
      goal = target;
    end
    else
    begin
      goal = 16'h0000;
    end
    // Terminal picks the time pair; rise or fall picks the time.
    if (goal > s_reg.freq)
    begin
      ramp_t = i_time_pair_b ? s_reg.ramp_up_time_b : s_reg.ramp_up_time_a;
    end
    else
    begin
      ramp_t = i_time_pair_b ? s_reg.ramp_down_time_b : s_reg.ramp_down_time_a;
    end
    den = 24'(ramp_t) * 24'(TICKS_PER_TENTH);
  end

  assign tick = (32'(s_reg.tick_cnt) == 32'(TICK_LEN - 1));
  assign rd_take = i_avs.read && !s_reg.ack;
  assign wr_fire = i_avs.write && s_reg.ack;
  // One wait cycle on every access.
  assign o_avs_waitrequest = (i_avs.read || i_avs.write) && !s_reg.ack;
  assign o_avs_readdata = s_reg.rdata;
  assign o_drive.run = (s_reg.mode != ST_IDLE);
  assign o_drive.reverse = s_reg.rev;
  assign o_drive.freq = s_reg.freq;
  assign o_drive.carrier = s_reg.carrier_freq;
  assign o_drive.avr_on = s_reg.avr_on;
  assign o_drive.decel = s_reg.decel;
  assign o_fault_clear = s_reg.fault_clr;

  // Next-state logic for registers, run sequence, ramp and bus.
  always_comb
  begin
    s_next = s_reg;
    s_next.fault_clr = 1'b0;
    // Restore defaults after reset or on command.
    if (!s_reg.init_done || s_reg.param_restore_cmd == RST_DEFAULTS)
    begin
      s_next.init_done = 1'b1;
      s_next.max_output_freq = FREQ_DEF;
      s_next.upper_freq_limit = FREQ_DEF;
      s_next.lower_freq_limit = 16'h0000;
      s_next.keypad_freq_setpoint = FREQ_DEF;
      s_next.ramp_up_time_a = TIME_DEF;
      s_next.ramp_down_time_a = TIME_DEF;
      s_next.ramp_up_time_b = TIME_DEF;
      s_next.ramp_down_time_b = TIME_DEF;
      s_next.direction_policy = DIR_NO_REV;
      s_next.carrier_freq = carr_def;
      s_next.voltage_regulation_mode = AVR_ON;
      s_next.freq_source_select = SRC_KEYPAD;
      s_next.param_restore_cmd = RST_NONE;
    end
    else if (s_reg.param_restore_cmd == RST_FAULTS)
    begin
      s_next.fault_clr = 1'b1;
      s_next.param_restore_cmd = RST_NONE;
    end
    else if (s_reg.param_restore_cmd != RST_NONE)
    begin
      s_next.param_restore_cmd = RST_NONE;
    end
    // Run sequencer.
    unique case (s_reg.mode)
      ST_IDLE:
      begin
        // Start refused below the lower limit.
        if (i_run_req && s_reg.init_done && sp[15:0] >= s_reg.lower_freq_limit)
        begin
          s_next.mode = ST_RUN;
          s_next.rev = forbid ? 1'b0 : want_rev;
        end
      end
      ST_RUN:
      begin
        if (!i_run_req)
        begin
          s_next.mode = ST_STOP;
        end
        else if (s_reg.freq == 16'h0000 && want_rev != s_reg.rev && !forbid)
        begin
          s_next.rev = want_rev;
        end
      end
      ST_STOP:
      begin
        if (i_run_req)
        begin
          s_next.mode = ST_RUN;
        end
        else if (s_reg.freq == 16'h0000)
        begin
          s_next.mode = ST_IDLE;
        end
      end
    endcase
    // Ramp: each tick adds the maximum; each clock pays at most one 0.01 Hz step.
    s_next.tick_cnt = tick ? 16'h0000 : s_reg.tick_cnt + 16'h0001;
    if (goal == s_reg.freq)
    begin
      s_next.acc = 24'h000000;
    end
    else if (s_reg.acc >= den)
    begin
      // A tick that lands on a step still adds, so no slope is lost.
      s_next.acc = s_reg.acc - den + (tick ? 24'(s_reg.max_output_freq) : 24'h000000);
      s_next.freq = (goal > s_reg.freq) ? s_reg.freq + 16'h0001 : s_reg.freq - 16'h0001;
    end
    else if (tick)
    begin
      s_next.acc = s_reg.acc + 24'(s_reg.max_output_freq);
    end
    s_next.decel = (goal < s_reg.freq);
    // Regulation flag for the stage.
    s_next.avr_on = (s_reg.voltage_regulation_mode == AVR_ON) ||
                    (s_reg.voltage_regulation_mode == AVR_NO_DECEL && goal >= s_reg.freq);
    // Bus: latch read data first edge, act on the second.
    if (rd_take || (i_avs.write && !s_reg.ack))
    begin
      s_next.ack = 1'b1;
    end
    else
    begin
      s_next.ack = 1'b0;
    end
    if (rd_take)
    begin
      unique case (i_avs.address)
        ADDR_MAX_F: s_next.rdata = {16'h0000, s_reg.max_output_freq};
        ADDR_UPPER_F: s_next.rdata = {16'h0000, s_reg.upper_freq_limit};
        ADDR_LOWER_F: s_next.rdata = {16'h0000, s_reg.lower_freq_limit};
        ADDR_KEYPAD_F: s_next.rdata = {16'h0000, s_reg.keypad_freq_setpoint};
        ADDR_UP_A: s_next.rdata = {16'h0000, s_reg.ramp_up_time_a};
        ADDR_DN_A: s_next.rdata = {16'h0000, s_reg.ramp_down_time_a};
        ADDR_DIR: s_next.rdata = {30'h00000000, s_reg.direction_policy};
        ADDR_CARRIER: s_next.rdata = {16'h0000, s_reg.carrier_freq};
        ADDR_RESTORE: s_next.rdata = {30'h00000000, s_reg.param_restore_cmd};
        ADDR_AVR: s_next.rdata = {30'h00000000, s_reg.voltage_regulation_mode};
        ADDR_UP_B: s_next.rdata = {16'h0000, s_reg.ramp_up_time_b};
        ADDR_DN_B: s_next.rdata = {16'h0000, s_reg.ramp_down_time_b};
        ADDR_SRC: s_next.rdata = {29'h00000000, s_reg.freq_source_select};
        ADDR_STATUS: s_next.rdata = {27'h0000000, s_reg.avr_on, s_reg.decel, s_reg.rev,
                                     s_reg.mode};
        ADDR_OUT_F: s_next.rdata = {16'h0000, s_reg.freq};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
    // Numeric writes clamp into legal ranges, illegal codes are ignored; a bus write wins over self-clear.
    if (wr_fire)
    begin
      unique case (i_avs.address)
        ADDR_MAX_F: s_next.max_output_freq = clamp16(merge16(s_reg.max_output_freq,
          i_avs.writedata, i_avs.byteenable), MAX_F_MIN, MAX_F_MAX);
        ADDR_UPPER_F: s_next.upper_freq_limit = clamp16(merge16(s_reg.upper_freq_limit,
          i_avs.writedata, i_avs.byteenable), s_reg.lower_freq_limit,
          s_reg.max_output_freq);
        ADDR_LOWER_F: s_next.lower_freq_limit = clamp16(merge16(s_reg.lower_freq_limit,
          i_avs.writedata, i_avs.byteenable), 16'h0000, s_reg.upper_freq_limit);
        ADDR_KEYPAD_F: s_next.keypad_freq_setpoint = clamp16(merge16(
          s_reg.keypad_freq_setpoint, i_avs.writedata, i_avs.byteenable), 16'h0000,
          s_reg.max_output_freq);
        ADDR_UP_A: s_next.ramp_up_time_a = clamp16(merge16(s_reg.ramp_up_time_a,
          i_avs.writedata, i_avs.byteenable), TIME_MIN, TIME_MAX);
        ADDR_DN_A: s_next.ramp_down_time_a = clamp16(merge16(s_reg.ramp_down_time_a,
          i_avs.writedata, i_avs.byteenable), TIME_MIN, TIME_MAX);
        ADDR_UP_B: s_next.ramp_up_time_b = clamp16(merge16(s_reg.ramp_up_time_b,
          i_avs.writedata, i_avs.byteenable), TIME_MIN, TIME_MAX);
        ADDR_DN_B: s_next.ramp_down_time_b = clamp16(merge16(s_reg.ramp_down_time_b,
          i_avs.writedata, i_avs.byteenable), TIME_MIN, TIME_MAX);
        ADDR_CARRIER: s_next.carrier_freq = clamp16(merge16(s_reg.carrier_freq,
          i_avs.writedata, i_avs.byteenable), CARR_MIN, carr_hi);
        ADDR_DIR:
        begin
          if (i_avs.byteenable[0] && i_avs.writedata[1:0] <= DIR_NO_REV)
          begin
            s_next.direction_policy = i_avs.writedata[1:0];
          end
        end
        ADDR_RESTORE:
        begin
          if (i_avs.byteenable[0] && i_avs.writedata[1:0] <= RST_FAULTS)
          begin
            s_next.param_restore_cmd = i_avs.writedata[1:0];
          end
        end
        ADDR_AVR:
        begin
          if (i_avs.byteenable[0] && i_avs.writedata[1:0] <= AVR_NO_DECEL)
          begin
            s_next.voltage_regulation_mode = i_avs.writedata[1:0];
          end
        end
        ADDR_SRC:
        begin
          if (i_avs.byteenable[0] && i_avs.writedata[2:0] <= SRC_COMM)
          begin
            s_next.freq_source_select = i_avs.writedata[2:0];
          end
        end
        default:
        begin
          s_next.rdata = s_reg.rdata;
        end
      endcase
    end
  end

  // State register; reset clears all, defaults load on the next edge.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  // Bus handshake: one wait cycle, then release.
  sequence bus_req_s;
    (i_avs.read || i_avs.write) && !s_reg.ack;
  endsequence
  sequence bus_done_s;
    !o_avs_waitrequest ##1 !s_reg.ack;
  endsequence
  a_bus_wait_once: assert property (bus_req_s |-> o_avs_waitrequest ##1 bus_done_s)
    else $error("bus access did not finish after one wait cycle");

  a_low_start_refused: assert property (
    s_reg.mode == ST_IDLE && sp[15:0] < s_reg.lower_freq_limit |=> s_reg.mode == ST_IDLE)
    else $error("start taken below lower limit");

  a_goal_upper_clamp: assert property (
    s_reg.freq > s_reg.upper_freq_limit |=> s_reg.freq <= $past(s_reg.freq))
    else $error("frequency rose while above upper limit");

  a_restore_self_clear: assert property (
    s_reg.init_done && s_reg.param_restore_cmd != RST_NONE && !wr_fire
    |=> s_reg.param_restore_cmd == RST_NONE)
    else $error("restore field not cleared");

  a_fault_erase_pulse: assert property (
    s_reg.init_done && s_reg.param_restore_cmd == RST_FAULTS |=> o_fault_clear ##1 !o_fault_clear)
    else $error("fault erase pulse missing");

  a_no_reverse_start: assert property (
    $rose(s_reg.rev) |-> $past(s_reg.direction_policy) != DIR_NO_REV)
    else $error("reverse entered while forbidden");

  a_avr_off_mode: assert property (
    s_reg.voltage_regulation_mode == AVR_OFF && $past(s_reg.voltage_regulation_mode) == AVR_OFF
    |-> !o_drive.avr_on)
    else $error("regulation on while disabled");

  a_ramp_single_step: assert property (
    $changed(s_reg.freq) |-> s_reg.freq == $past(s_reg.freq) + 16'h0001 ||
    s_reg.freq == $past(s_reg.freq) - 16'h0001)
    else $error("frequency jumped more than one step");

  a_dir_flip_zero: assert property (
    $changed(s_reg.rev) |-> $past(s_reg.freq) == 16'h0000)
    else $error("direction changed at speed");

  a_carrier_bounds: assert property (
    s_reg.init_done |-> s_reg.carrier_freq >= CARR_MIN && s_reg.carrier_freq <= CARR_MAX_S)
    else $error("carrier outside bounds");

  a_max_freq_range: assert property (
    s_reg.init_done |-> s_reg.max_output_freq >= MAX_F_MIN &&
    s_reg.max_output_freq <= MAX_F_MAX)
    else $error("maximum frequency outside range");
endmodule

// [dv/fsr_stage_model.sv]
// Purpose: Power stage and remote host stand-in on the far side of the drive port.
// Assumes: Frequencies in 0.01 Hz; source frequencies are held as steady levels.
// Notes: The stage flags any direction flip made while the motor still turns.
`timescale 1ns/1ps
module fsr_stage_model
  import fsr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire fsr_drive_s i_drive,
  output logic [15:0] o_step_freq,
  output logic [15:0] o_loop_freq,
  output logic [15:0] o_comm_freq,
  output logic o_dir_glitch
);
  // Step table entry, loop regulator output and host command, each distinct.
  assign o_step_freq = 16'h0096;
  assign o_loop_freq = 16'h00C8;
  assign o_comm_freq = 16'h0064;
  logic prev_rev; // Direction seen last cycle.
  logic [15:0] prev_f; // Frequency seen last cycle.
  // A flip at speed would jerk the shaft, so it is latched as a fault.
  always_ff @(posedge i_ref_clk)
  begin
    prev_rev <= i_drive.reverse;
    prev_f <= i_drive.freq;
    if (i_sys_rst)
      o_dir_glitch <= 1'b0;
    else if (i_drive.reverse !== prev_rev && prev_f !== 16'h0 && i_drive.freq !== 16'h0)
      o_dir_glitch <= 1'b1;
  end
endmodule

// [dv/fsr_ramp_ctrl_tb.sv]
// Purpose: Self-checking bench for the setpoint and ramp block.
// Assumes: TICK_LEN is cut to 40 cycles; ramp durations scale with it.
// Notes: Register rows first, then start, ramp, direction, source and restore cases.
`timescale 1ns/1ps
module fsr_ramp_ctrl_tb;
  import fsr_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] e;} fsr_row_s;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  fsr_avs_req_s i_avs = '0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic i_run_req = 1'b0;
  logic i_run_rev = 1'b0;
  logic i_time_pair_b = 1'b0;
  logic [1:0] i_model_class = 2'h0;
  logic signed [15:0] volt_in = 16'sh0000;
  logic signed [15:0] curr_in = 16'sh0000;
  logic [15:0] step_f, loop_f, comm_f;
  fsr_drive_s o_drive;
  logic o_fault_clear, glitch;
  int errors = 0;
  int checked = 0;
  logic [31:0] q;
  int n;
  // Each row: optional write, then a read expected to give e.
  fsr_row_s rows [16] = '{
    '{1'b0, ADDR_MAX_F, 16'h0, FREQ_DEF}, '{1'b0, ADDR_UPPER_F, 16'h0, FREQ_DEF},
    '{1'b0, ADDR_LOWER_F, 16'h0, 16'h0}, '{1'b0, ADDR_KEYPAD_F, 16'h0, FREQ_DEF},
    '{1'b0, ADDR_UP_A, 16'h0, TIME_DEF}, '{1'b0, ADDR_DN_A, 16'h0, TIME_DEF},
    '{1'b0, ADDR_DIR, 16'h0, 16'h2}, '{1'b0, ADDR_CARRIER, 16'h0, CARR_DEF_S},
    '{1'b0, ADDR_RESTORE, 16'h0, 16'h0}, '{1'b0, ADDR_AVR, 16'h0, 16'h1},
    '{1'b0, ADDR_SRC, 16'h0, 16'h0}, '{1'b0, 8'h40, 16'h0, 16'h0},
    '{1'b1, ADDR_DIR, 16'h3, 16'h2}, '{1'b1, ADDR_CARRIER, 16'h00FF, CARR_MAX_S},
    '{1'b1, ADDR_SRC, 16'h7, 16'h0}, '{1'b1, ADDR_AVR, 16'h2, 16'h2}};
  fsr_ramp_ctrl #(.TICK_LEN(40)) DUT (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_avs(i_avs), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_run_req(i_run_req), .i_run_rev(i_run_rev), .i_time_pair_b(i_time_pair_b),
    .i_model_class(i_model_class), .i_voltage_analog_input(volt_in),
    .i_current_analog_input(curr_in),
    .i_step_freq(step_f), .i_loop_freq(loop_f), .i_comm_freq(comm_f),
    .o_drive(o_drive), .o_fault_clear(o_fault_clear));
  fsr_stage_model u_stage (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_drive(o_drive),
    .o_step_freq(step_f), .o_loop_freq(loop_f), .o_comm_freq(comm_f), .o_dir_glitch(glitch));
  // Clock of 25 ns period.
  always #12.5 i_ref_clk = ~i_ref_clk;
  // Prints counts and verdict, then stops the run.
  task automatic summarize();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One Avalon-MM access, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge i_ref_clk);
    i_avs <= '{a, ~wr, wr, {16'h0, d}, 4'h3};
    for (k = 0; k < 20; k++)
    begin
      @(posedge i_ref_clk);
      if (o_avs_waitrequest === 1'b0)
        break;
    end
    r = o_avs_readdata;
    i_avs <= '0;
    if (k == 20)
    begin
      errors++;
      summarize();
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // Waits for frequency v (kind 0), direction v (kind 1) or a fault-clear pulse (kind 2).
  task automatic wait_for(input int kind, input logic [15:0] v, output int c);
    for (c = 0; c < 1000; c++)
    begin
      @(posedge i_ref_clk);
      if ((kind == 0 && o_drive.freq === v) || (kind == 1 && o_drive.reverse === v[0]) ||
          (kind == 2 && o_fault_clear === 1'b1))
        break;
    end
    if (c == 1000)
    begin
      errors++;
      summarize();
    end
  endtask
  // Main sequence: reset, register rows, then the hand-written cases.
  initial
  begin
    repeat (6) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        put(rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 16'h0, q);
      chk(q, {16'h0, rows[i].e});
    end
    $display("register rows done");
    put(ADDR_KEYPAD_F, 16'h0064);
    put(ADDR_LOWER_F, 16'h00C8);
    i_run_req <= 1'b1;
    repeat (20) @(posedge i_ref_clk);
    chk(o_drive.run, 1'b0);
    put(ADDR_UP_A, 16'h0002);
    put(ADDR_DN_A, 16'h0002);
    put(ADDR_LOWER_F, 16'h0000);
    wait_for(0, 16'h0064, n);
    chk(n >= 110 && n <= 210, 1'b1);
    chk(o_drive.run, 1'b1);
    $display("start and ramp done");
    put(ADDR_UPPER_F, 16'h0032);
    wait_for(0, 16'h0032, n);
    i_run_rev <= 1'b1;
    repeat (150) @(posedge i_ref_clk);
    chk(o_drive.reverse, 1'b0);
    chk(o_drive.freq, 16'h0000);
    i_run_rev <= 1'b0;
    put(ADDR_DIR, 16'h0001);
    wait_for(1, 16'h0001, n);
    put(ADDR_UPPER_F, FREQ_DEF);
    put(ADDR_SRC, {13'h0, SRC_LOOP});
    wait_for(0, 16'h00C8, n);
    put(ADDR_SRC, {13'h0, SRC_STEP});
    wait_for(0, 16'h0096, n);
    put(ADDR_SRC, {13'h0, SRC_COMM});
    wait_for(0, 16'h0064, n);
    chk(glitch, 1'b0);
    $display("direction and source done");
    put(ADDR_RESTORE, {14'h0, RST_DEFAULTS});
    bus(1'b0, ADDR_RESTORE, 16'h0, q);
    chk(q, 32'h0);
    bus(1'b0, ADDR_DIR, 16'h0, q);
    chk(q, 32'h2);
    bus(1'b0, ADDR_UP_A, 16'h0, q);
    chk(q, {16'h0, TIME_DEF});
    put(ADDR_RESTORE, {14'h0, RST_FAULTS});
    wait_for(2, 16'h0, n);
    bus(1'b0, ADDR_RESTORE, 16'h0, q);
    chk(q, 32'h0);
    $display("restore done");
    chk(o_drive.carrier, CARR_DEF_S);
    i_model_class <= 2'h2;
    put(ADDR_CARRIER, 16'h00FF);
    @(posedge i_ref_clk);
    chk(o_drive.carrier, CARR_MAX_L);
    put(ADDR_KEYPAD_F, 16'h0064);
    i_time_pair_b <= 1'b1;
    put(ADDR_UP_B, 16'h0002);
    put(ADDR_DN_B, 16'h0002);
    wait_for(1, 16'h0000, n);
    wait_for(0, 16'h0064, n);
    put(ADDR_AVR, {14'h0, AVR_OFF});
    repeat (2) @(posedge i_ref_clk);
    chk(o_drive.avr_on, 1'b0);
    put(ADDR_AVR, {14'h0, AVR_NO_DECEL});
    repeat (2) @(posedge i_ref_clk);
    chk(o_drive.avr_on, 1'b1);
    put(ADDR_KEYPAD_F, 16'h0000);
    repeat (2) @(posedge i_ref_clk);
    chk({o_drive.decel, o_drive.avr_on}, 2'h2);
    $display("carrier, time pair and regulation done");
    volt_in <= 16'sh0014;
    curr_in <= 16'sh000A;
    put(ADDR_SRC, {13'h0, SRC_VOLT});
    wait_for(0, 16'h0064, n);
    put(ADDR_SRC, {13'h0, SRC_CURR});
    wait_for(0, 16'h0032, n);
    put(ADDR_SRC, {13'h0, SRC_SUM});
    wait_for(0, 16'h0096, n);
    $display("analog sources done");
    i_sys_rst <= 1'b1;
    i_run_req <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    chk(o_drive.run, 1'b0);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk(o_drive.carrier, CARR_DEF_L);
    bus(1'b0, ADDR_MAX_F, 16'h0, q);
    chk(q, {16'h0, FREQ_DEF});
    $display("mid-run reset done");
    summarize();
  end
endmodule
